// *** common/ses_pkg.sv ***
/*
  Constants, target codes and state encoding for the two-wire serial slave
  of the sensor/SPD memory front end.
  Assumes a 125 MHz system clock and a host-driven serial clock on the link.
*/
package ses_pkg;

  // ****************************************************************
  // Addressing
  // ****************************************************************
  localparam logic [7:0] PTR_RESET = 8'h00;    // Pointer after power-up
  localparam logic [3:0] MEM_ID = 4'hA;        // Fixed pattern for the array
  localparam logic [3:0] PROT_ID = 4'h6;       // Fixed pattern for protection
  localparam logic [3:0] SEN_ID = 4'h3;        // Fixed pattern for sensor registers
  localparam int MEM_BYTES = 256;
  localparam int PAGE_BYTES = 16;

  // Targets of a frame
  localparam logic [1:0] TGT_MEM = 2'h0;
  localparam logic [1:0] TGT_SEN = 2'h1;
  localparam logic [1:0] TGT_PROT = 2'h2;

  // Protection command classes
  localparam logic [1:0] PCMD_PERM = 2'h0;
  localparam logic [1:0] PCMD_REV = 2'h1;
  localparam logic [1:0] PCMD_CLR = 2'h2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 125;
  localparam int CONV_TIME_MS = 125;
  localparam int CONV_CYCLES = CONV_TIME_MS * CLK_MHZ * 1000;
  localparam int NV_WRITE_US = 5;
  localparam int NV_WRITE_CYCLES = NV_WRITE_US * CLK_MHZ;
  localparam logic [3:0] ACK_SLOT = 4'h8;      // Bit count of the ninth clock
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ****************************************************************
  // Frame states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WORD = 3'b010,
    ST_WDATA = 3'b011,
    ST_TX = 3'b100,
    ST_PROT = 3'b101,
    ST_IGNORE = 3'b110
  } ses_state_type;

endpackage

// *** rtl/ses_spd_slave.sv ***
/*
  Two-wire serial slave for a sensor with an on-chip 256-byte SPD array:
  pointer access to 16-bit sensor registers, byte/page array writes,
  acknowledge polling, current/sequential reads and write protection.
  Assumes scl_clk and scl_in carry the same host serial clock, the
  sensor register file sits outside on sys_clk, and protection state is
  kept in nonvolatile storage outside and offered back after reset.
*/
`timescale 1ns/1ps
module ses_spd_slave #(
  parameter int NV_CYCLES = ses_pkg::NV_WRITE_CYCLES,
  parameter int CONV_CYC = ses_pkg::CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [2:0] sel_pin,
  input wire logic sel_ov_det,
  input wire logic prot_perm_init,
  input wire logic prot_rev_init,
  output logic prot_perm,
  output logic prot_rev,
  output logic nv_busy,
  output logic [7:0] reg_ptr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  output logic conv_tick
);
  import ses_pkg::*;

  // ****************************************************************
  // Link side: capture each bit on the host clock
  // ****************************************************************
  logic bit_cap_r;
  logic bit_tgl_r;

  // Sample data on rising serial clock and flag it by a toggle
  always_ff @(posedge scl_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cap_r <= 1'b0;
      bit_tgl_r <= 1'b0;
    end else begin
      bit_cap_r <= sda_in;
      bit_tgl_r <= ~bit_tgl_r;
    end
  end

  // ****************************************************************
  // Crossings into the system clock
  // ****************************************************************
  logic [5:0] pin_s;
  logic [0:0] tgl_s;

  ses_sync #(.WIDTH(6)) u_pin_sync (
    .clk(sys_clk),
    .arst_n(arst_n),
    .din({scl_in, sda_in, sel_ov_det, sel_pin}),
    .dout(pin_s)
  );

  ses_sync #(.WIDTH(1)) u_tgl_sync (
    .clk(sys_clk),
    .arst_n(arst_n),
    .din(bit_tgl_r),
    .dout(tgl_s)
  );

  // ****************************************************************
  // Frame state
  // ****************************************************************
  ses_state_type state_r;
  logic scl_d_r, sda_d_r, tgl_d_r;
  logic [3:0] cnt_r;
  logic [6:0] sh_r;
  logic ack_r, tx_live_r;
  logic [7:0] tx_byte_r;
  logic [1:0] tgt_r, pcmd_r;
  logic prot_rd_r, prot_hit_r, prot_pend_r;
  logic [7:0] addr_r;
  logic [3:0] page_r;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_r;
  logic mem_pend_r, sen_hi_r, sen_lo_r;
  logic [7:0] wd_hi_r;
  logic [15:0] rd_word_r;
  logic perm_r, rev_r, load_done_r;
  logic [31:0] busy_cnt_r, conv_cnt_r;
  // Array kept as one column per in-page offset, so each commit lane owns its column
  logic [7:0] mem [PAGE_BYTES][MEM_BYTES/PAGE_BYTES];

  // Bus events from the synchronised pins
  wire scl_s = pin_s[5];
  wire sda_s = pin_s[4];
  wire ov_s = pin_s[3];
  wire [2:0] sel_s = pin_s[2:0];
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire scl_fall = scl_d_r & ~scl_s;
  wire bit_rise = tgl_s[0] ^ tgl_d_r;
  wire byte_done = bit_rise & (cnt_r == LAST_BIT);
  wire ack_rise = bit_rise & (cnt_r == ACK_SLOT);
  wire [7:0] rx_byte = {sh_r, bit_cap_r};
  wire tx_mode = (state_r == ST_TX) & tx_live_r;

  // Slave byte decode
  wire rw_bit = rx_byte[0];
  wire hw_ok = (rx_byte[3:1] == {sel_s[2:1], sel_s[0] | ov_s});
  wire is_mem = (rx_byte[7:4] == MEM_ID) & hw_ok;
  wire is_sen = (rx_byte[7:4] == SEN_ID) & hw_ok;
  wire is_prot = (rx_byte[7:4] == PROT_ID) & hw_ok;
  wire [1:0] pcmd_dec = !ov_s ? PCMD_PERM : (sel_s[1] ? PCMD_CLR : PCMD_REV);
  wire prot_ins_ack = ~perm_r & ~(rev_r & (pcmd_dec == PCMD_REV));
  wire addr_ack = ~nv_busy & (is_mem | is_sen | (is_prot & prot_ins_ack));
  wire low_locked = (perm_r | rev_r) & ~addr_r[7];
  wire [3:0] idx_bit = 4'h7 - cnt_r;

  // ****************************************************************
  // Bit counter, shifter and open-drain drive
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tgl_d_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 7'h00;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tgl_d_r <= tgl_s[0];
      sda_o <= 1'b0;
      if (start_det || stop_det) begin
        cnt_r <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        if (bit_rise) begin
          sh_r <= rx_byte[6:0];
          cnt_r <= (cnt_r == ACK_SLOT) ? 4'h0 : cnt_r + 4'h1;
        end
        if (scl_fall) begin
          sda_oe <= (cnt_r == ACK_SLOT) ? (~tx_mode & ack_r) : (tx_mode & ~tx_byte_r[idx_bit[2:0]]);
        end
      end
    end
  end

  // ****************************************************************
  // Byte level protocol
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      ack_r <= 1'b0;
      tx_live_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tgt_r <= TGT_MEM;
      pcmd_r <= PCMD_PERM;
      prot_rd_r <= 1'b0;
      prot_hit_r <= 1'b0;
      prot_pend_r <= 1'b0;
      addr_r <= 8'h00;
      page_r <= 4'h0;
      page_vld_r <= '0;
      mem_pend_r <= 1'b0;
      sen_hi_r <= 1'b0;
      sen_lo_r <= 1'b0;
      wd_hi_r <= 8'h00;
      rd_word_r <= 16'h0000;
      reg_ptr <= PTR_RESET;
      reg_wr <= 1'b0;
      reg_wdata <= 16'h0000;
      reg_rd <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (start_det) begin
        // Repeated start keeps the loaded address for a selective read
        state_r <= ST_ADDR;
        tx_live_r <= 1'b0;
        ack_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        tx_live_r <= 1'b0;
        ack_r <= 1'b0;
        mem_pend_r <= 1'b0;
        prot_pend_r <= 1'b0;
        page_vld_r <= '0;
      end else if (byte_done) begin
        case (state_r)
          ST_ADDR: begin
            ack_r <= addr_ack;
            tgt_r <= is_mem ? TGT_MEM : (is_sen ? TGT_SEN : TGT_PROT);
            pcmd_r <= pcmd_dec;
            prot_rd_r <= rw_bit;
            prot_hit_r <= 1'b0;
            sen_hi_r <= 1'b0;
            if (!addr_ack) begin
              state_r <= ST_IGNORE;
            end else if (is_prot) begin
              state_r <= ST_PROT;
            end else if (rw_bit) begin
              state_r <= ST_TX;
              if (is_mem) begin
                tx_byte_r <= mem[addr_r[3:0]][addr_r[7:4]];
                addr_r <= addr_r + 8'h01;
              end else begin
                rd_word_r <= reg_rdata;
                tx_byte_r <= reg_rdata[15:8];
                sen_lo_r <= 1'b1;
                reg_rd <= 1'b1;
              end
            end else begin
              state_r <= ST_WORD;
            end
          end
          ST_WORD: begin
            ack_r <= 1'b1;
            state_r <= ST_WDATA;
            if (tgt_r == TGT_SEN) begin
              reg_ptr <= rx_byte;
            end else begin
              addr_r <= rx_byte;
              page_r <= rx_byte[7:4];
              // A new array address drops all bytes still pending, whichever page they were for
              page_vld_r <= '0;
              mem_pend_r <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (tgt_r == TGT_SEN) begin
              ack_r <= 1'b1;
              sen_hi_r <= ~sen_hi_r;
              if (!sen_hi_r) begin
                wd_hi_r <= rx_byte;
              end else begin
                reg_wdata <= {wd_hi_r, rx_byte};
                reg_wr <= 1'b1;
              end
            end else begin
              ack_r <= ~low_locked;
              if (!low_locked) begin
                page_buf[addr_r[3:0]] <= rx_byte;
                page_vld_r[addr_r[3:0]] <= 1'b1;
                mem_pend_r <= 1'b1;
              end
              addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
            end
          end
          ST_PROT: begin
            ack_r <= ~prot_rd_r;
            prot_hit_r <= 1'b1;
            prot_pend_r <= prot_hit_r & ~prot_rd_r;
          end
          default: begin
            ack_r <= 1'b0;
          end
        endcase
      end else if (ack_rise && state_r == ST_TX) begin
        if (!tx_live_r) begin
          tx_live_r <= 1'b1;
        end else if (bit_cap_r) begin
          state_r <= ST_IGNORE;
        end else if (tgt_r == TGT_MEM) begin
          tx_byte_r <= mem[addr_r[3:0]][addr_r[7:4]];
          addr_r <= addr_r + 8'h01;
        end else begin
          sen_lo_r <= ~sen_lo_r;
          tx_byte_r <= sen_lo_r ? rd_word_r[7:0] : reg_rdata[15:8];
          if (!sen_lo_r) begin
            rd_word_r <= reg_rdata;
            reg_rd <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Array commit on stop; array itself has no reset
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_commit
      always_ff @(posedge sys_clk) begin
        if (stop_det && mem_pend_r && page_vld_r[gi]) begin
          mem[gi][page_r] <= page_buf[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Protection state and write cycle timer
  // ****************************************************************
  wire mem_start = stop_det & mem_pend_r;
  wire prot_start = stop_det & prot_pend_r & ((pcmd_r != PCMD_CLR) | rev_r);
  wire [31:0] nv_len = 32'(NV_CYCLES);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      perm_r <= 1'b0;
      rev_r <= 1'b0;
      load_done_r <= 1'b0;
      nv_busy <= 1'b0;
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      load_done_r <= 1'b1;
      if (!load_done_r) begin
        perm_r <= prot_perm_init;
        rev_r <= prot_rev_init;
      end else if (prot_start) begin
        perm_r <= perm_r | (pcmd_r == PCMD_PERM);
        rev_r <= (pcmd_r == PCMD_REV) | (rev_r & (pcmd_r == PCMD_PERM));
      end
      if (mem_start || prot_start) begin
        nv_busy <= 1'b1;
        busy_cnt_r <= nv_len - 32'h1;
      end else if (busy_cnt_r != 32'h0) begin
        busy_cnt_r <= busy_cnt_r - 32'h1;
      end else begin
        nv_busy <= 1'b0;
      end
    end
  end

  assign prot_perm = perm_r;
  assign prot_rev = rev_r;

  // ****************************************************************
  // Conversion pacing
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt_r <= 32'h0000_0000;
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= (conv_cnt_r == 32'(CONV_CYC - 1));
      conv_cnt_r <= (conv_cnt_r == 32'(CONV_CYC - 1)) ? 32'h0 : conv_cnt_r + 32'h1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_busy_addr_nack: assert property (
    byte_done && state_r == ST_ADDR && nv_busy |=> !ack_r && state_r == ST_IGNORE)
    else $error("address acked during write cycle");
  a_match_needed: assert property (
    byte_done && state_r == ST_ADDR && !hw_ok |=> !ack_r)
    else $error("address acked on hardware bit mismatch");
  a_locked_data_nack: assert property (
    byte_done && state_r == ST_WDATA && tgt_r == TGT_MEM && low_locked |=> !ack_r && !mem_pend_r)
    else $error("protected data byte acked");
  a_page_wrap: assert property (
    byte_done && state_r == ST_WDATA && tgt_r == TGT_MEM
    |=> addr_r[7:4] == $past(addr_r[7:4]) && addr_r[3:0] == $past(addr_r[3:0]) + 4'h1)
    else $error("page address left its page");
  a_perm_final: assert property (
    load_done_r && perm_r |=> perm_r)
    else $error("permanent protection cleared");
  a_busy_hold: assert property (
    $rose(nv_busy) |-> nv_busy[*8])
    else $error("write cycle ended early");
  a_sensor_pair: assert property (
    byte_done && state_r == ST_WDATA && tgt_r == TGT_SEN && sen_hi_r
    |=> reg_wr && reg_wdata == {$past(wd_hi_r), $past(rx_byte)})
    else $error("register write not formed from two bytes");
  a_ptr_hold: assert property (
    !(byte_done && state_r == ST_WORD && tgt_r == TGT_SEN) |=> $stable(reg_ptr))
    else $error("pointer changed without a pointer byte");
  a_msb_first: assert property (
    scl_fall && !start_det && !stop_det && tx_mode && cnt_r == 4'h0 |=> sda_oe == !$past(tx_byte_r[7]))
    else $error("first transmitted bit is not the top bit");
  a_prot_read_nack: assert property (
    byte_done && state_r == ST_PROT && prot_rd_r |=> !ack_r)
    else $error("protection read byte acked");
  a_conv_space: assert property (
    conv_tick |=> !conv_tick [*8])
    else $error("conversions closer than the period");

endmodule // ses_spd_slave

// *** rtl/ses_sync.sv ***
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level or a toggle; no bus coherence is given.
*/
`timescale 1ns/1ps
module ses_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // ****************************************************************
  // Two stages, the first read only by the second
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule // ses_sync

// *** verification/ses_host_model.sv ***
/*
  Behavioural two-wire bus master for the serial slave bench.
  Assumes an external pull-up on SDA: the model only ever pulls it low,
  and SCL stands high between frames.
*/
`timescale 1ns/1ps
module ses_host_model #(
  parameter int Q = 67  // Quarter bit time, off the system clock grid
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // ****************************************************************
  // Bus conditions and bit transfer
  // ****************************************************************
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // START or repeated START: SDA falls while SCL is high
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask

  // STOP: SDA rises while SCL is high; SCL then stands still
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(2 * Q);
  endtask

  // One bit: data changes only while SCL is low, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q s = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Eight data bits then the ninth clock; ack is 1 when SDA was low
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], rx[i]);
    bit_io(last, ack);
    ack = ~ack;
  endtask
endmodule // ses_host_model

// *** verification/ses_spd_slave_tb.sv ***
/*
  Self-checking bench for the serial slave: sensor pointer access, array
  writes and reads, polling and write protection.
  Assumes the host model above and the slave's hand-over timing.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[FAIL] %s exp %0h got %0h", nm, (e), (g)); end end
module ses_spd_slave_tb;
  import ses_pkg::*;
  localparam int NV = 400;
  localparam int CONV = 64;
  logic sys_clk, arst_n, sel_ov_det, scl, host_low, sda_o, sda_oe, prot_perm, prot_rev, nv_busy, reg_wr, reg_rd, conv_tick;
  logic ack, perm_init, rev_init;
  logic [2:0] sel_pin, pins;
  logic [7:0] reg_ptr, p, a;
  logic [7:0] mem [256];
  logic [15:0] reg_wdata, w;
  int errors, checked, bcnt, tcnt, gap, wcnt, rcnt;
  int cnt [5] = '{1, 2, 4, 8, 18};
  // Open-drain line with pull-up; sensor content follows the pointer
  wire sda_line = ~host_low & ((sda_oe === 1'b1) ? sda_o : 1'b1);
  wire [15:0] reg_rdata = {reg_ptr ^ 8'h5A, reg_ptr};

  ses_spd_slave #(.NV_CYCLES(NV), .CONV_CYC(CONV)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .scl_clk(scl),
    .scl_in(scl), .sda_in(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .sel_pin(sel_pin), .sel_ov_det(sel_ov_det),
    .prot_perm_init(perm_init), .prot_rev_init(rev_init), .prot_perm(prot_perm), .prot_rev(prot_rev),
    .nv_busy(nv_busy),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_tick(conv_tick));
  ses_host_model i_host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));

  // ****************************************************************
  // Clock, monitors and helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Busy length, tick spacing and register write pulses
  always @(posedge sys_clk) begin
    if (nv_busy === 1'b1) bcnt++;
    if (reg_wr === 1'b1) wcnt++;
    if (reg_rd === 1'b1) rcnt++;
    tcnt++;
    if (conv_tick === 1'b1) begin
      gap = tcnt;
      tcnt = 0;
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tx(input logic [7:0] d, input logic exp);
    logic [7:0] r;
    i_host.xbyte(d, 1'b1, r, ack);
    `CHK("ack", exp, ack)
  endtask

  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic x;
    i_host.xbyte(8'hFF, last, d, x);
  endtask

  // Select pins settle through the synchronisers before the next frame
  task automatic set_pins(input logic [2:0] v, input logic ov);
    @(posedge sys_clk);
    sel_pin <= v;
    sel_ov_det <= ov;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("idle", 1'b0, nv_busy)
    repeat (4) @(posedge sys_clk);
  endtask

  // Three-byte frame with don't-care address and data
  task automatic prot_cmd(input logic [7:0] sb, input logic e0, input logic e1, input logic cyc);
    i_host.start();
    tx(sb, e0);
    tx(8'($urandom), e1);
    tx(8'($urandom), e1);
    i_host.stop();
    repeat (8) @(posedge sys_clk);
    `CHK("cycle", cyc, nv_busy)
    wait_idle();
  endtask

  task automatic mem_write(input logic [7:0] ad, input int n, input logic dack);
    logic [7:0] d;
    i_host.start();
    tx({MEM_ID, pins, 1'b0}, 1'b1);
    tx(ad, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (dack) mem[{ad[7:4], ad[3:0] + 4'(i)}] = d;
      tx(d, dack);
    end
    bcnt = 0;
    i_host.stop();
  endtask

  // Dummy write of the address, repeated START, sequential read
  task automatic mem_check(input logic [7:0] ad, input int n);
    logic [7:0] d;
    i_host.start();
    tx({MEM_ID, pins, 1'b0}, 1'b1);
    tx(ad, 1'b1);
    i_host.start();
    tx({MEM_ID, pins, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      rx_byte(i == n - 1, d);
      `CHK("mem", mem[8'(ad + i)], d)
    end
    i_host.stop();
  endtask

  task automatic sen_read(input logic setp, input logic [7:0] pv);
    logic [7:0] hi, lo;
    rcnt = 0;
    i_host.start();
    if (setp) begin
      tx({SEN_ID, pins, 1'b0}, 1'b1);
      tx(pv, 1'b1);
      i_host.start();
    end
    tx({SEN_ID, pins, 1'b1}, 1'b1);
    rx_byte(1'b0, hi);
    rx_byte(1'b1, lo);
    i_host.stop();
    `CHK("rdata", {pv ^ 8'h5A, pv}, {hi, lo})
    `CHK("rd_count", 1, rcnt)
  endtask

  // ****************************************************************
  // Test sequence and watchdog
  // ****************************************************************
  initial begin
    #700_000;
    errors++;
    report_and_stop();
  end

  initial begin
    arst_n = 1'b0;
    sel_pin = 3'h0;
    sel_ov_det = 1'b0;
    perm_init = 1'b0;
    rev_init = 1'b0;
    void'($urandom(32'h142731b6));
    pins = 3'($urandom);
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    set_pins(pins, 1'b0);
    `CHK("ptr", PTR_RESET, reg_ptr)
    // Sensor pointer plus one register word
    p = 8'($urandom);
    w = 16'($urandom);
    i_host.start();
    tx({SEN_ID, pins, 1'b0}, 1'b1);
    tx(p, 1'b1);
    tx(w[15:8], 1'b1);
    tx(w[7:0], 1'b1);
    i_host.stop();
    `CHK("ptr", p, reg_ptr)
    `CHK("wdata", w, reg_wdata)
    `CHK("wr_count", 1, wcnt)
    sen_read(1'b0, p);
    sen_read(1'b1, 8'($urandom));
    // Wrong select bits and wrong fixed pattern
    for (int k = 0; k < 4; k++) begin
      i_host.start();
      tx(k < 3 ? {MEM_ID, pins ^ 3'(1 << k), 1'b1} : {4'h5, pins, 1'b1}, 1'b0);
      i_host.stop();
    end
    // Byte, partial and over-long page writes in the upper half
    foreach (cnt[k]) begin
      a = {4'(8 + k), 4'($urandom % (cnt[k] > 16 ? 16 : 17 - cnt[k]))};
      mem_write(a, cnt[k], 1'b1);
      i_host.start();
      tx({MEM_ID, pins, 1'b0}, 1'b0);
      i_host.stop();
      wait_idle();
      `CHK("busy_len", NV, bcnt)
      if (cnt[k] > 16) mem_check({a[7:4], 4'h0}, 16);
      else mem_check(a, cnt[k]);
    end
    // Reversible protection set, refused repeat, protected write
    set_pins({2'b00, pins[0]}, 1'b1);
    prot_cmd({PROT_ID, 4'b0010}, 1'b1, 1'b1, 1'b1);
    `CHK("rev", 1'b1, prot_rev)
    // Power cycle: stored protection offered back, pointer restarts
    perm_init <= prot_perm;
    rev_init <= prot_rev;
    arst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CHK("rev_kept", 1'b1, prot_rev)
    `CHK("ptr", PTR_RESET, reg_ptr)
    prot_cmd({PROT_ID, 4'b0011}, 1'b0, 1'b0, 1'b0);
    prot_cmd({PROT_ID, 4'b0010}, 1'b0, 1'b0, 1'b0);
    set_pins(pins, 1'b0);
    mem_write(8'($urandom % 128), 2, 1'b0);
    repeat (8) @(posedge sys_clk);
    `CHK("cycle", 1'b0, nv_busy)
    // Clear, then clear while unprotected
    set_pins({2'b01, pins[0]}, 1'b1);
    prot_cmd({PROT_ID, 4'b0111}, 1'b1, 1'b0, 1'b0);
    prot_cmd({PROT_ID, 4'b0110}, 1'b1, 1'b1, 1'b1);
    `CHK("rev", 1'b0, prot_rev)
    prot_cmd({PROT_ID, 4'b0110}, 1'b1, 1'b1, 1'b0);
    // Permanent protection, then protection commands and lower-half writes refused
    set_pins(pins, 1'b0);
    prot_cmd({PROT_ID, pins, 1'b0}, 1'b1, 1'b1, 1'b1);
    `CHK("perm", 1'b1, prot_perm)
    prot_cmd({PROT_ID, pins, 1'b1}, 1'b0, 1'b0, 1'b0);
    prot_cmd({PROT_ID, pins, 1'b0}, 1'b0, 1'b0, 1'b0);
    set_pins({2'b01, pins[0]}, 1'b1);
    prot_cmd({PROT_ID, 4'b0110}, 1'b0, 1'b0, 1'b0);
    set_pins(pins, 1'b0);
    mem_write(8'($urandom % 128), 1, 1'b0);
    repeat (8) @(posedge sys_clk);
    `CHK("cycle", 1'b0, nv_busy)
    `CHK("tick_gap", CONV, gap)
    report_and_stop();
  end
endmodule // ses_spd_slave_tb
